// ### design/uma_top.sv
/*
 * Mapped-array access to the unified and instruction translation
 * buffers: associative address-array writes and direct reads and
 * writes of data array 1.
 * Assumes the core drives i_req for one cycle per 32-bit access on
 * i_clk; answers come back one cycle later on o_rsp.
 */
// Overview of operation
// - Associative write compares all unified entries
// - No unified match: unified entries unchanged, no exception
// - Single match writes dirty and valid
// - Several matches raise multiple-hit exception
// - Same compare on instruction buffer, write valid
// - Instruction match updates even on unified miss
// - Both match: copy unified entry to instruction
// - Data array 1 window decoded
// - Select bits 31:23, entry bits 13:8
// - Page number, valid, size, protection positions
// - Cacheable, dirty, shared, write-through positions
`timescale 1ns/1ps
module uma_top #(
    parameter int UNIFIED_TRANSLATION_BUFFER_ENTRIES = uma_pkg::UNIFIED_TRANSLATION_BUFFER_ENTRIES,
    parameter int INSTRUCTION_TRANSLATION_BUFFER_ENTRIES = uma_pkg::INSTRUCTION_TRANSLATION_BUFFER_ENTRIES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire uma_pkg::uma_req_s i_req,
    input wire uma_pkg::uma_fill_s i_fill,
    input wire logic [uma_pkg::ASID_W-1:0] i_asid,
    output uma_pkg::uma_rsp_s o_rsp,
    output logic [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] o_instruction_translation_buffer_valid
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The entry select field is six bits wide, so exactly 64 entries
    generate
        if (UNIFIED_TRANSLATION_BUFFER_ENTRIES != 64) begin : g_bad_unified_translation_buffer
            $error("UNIFIED_TRANSLATION_BUFFER_ENTRIES must be 64");
        end
        if (INSTRUCTION_TRANSLATION_BUFFER_ENTRIES < 1 || INSTRUCTION_TRANSLATION_BUFFER_ENTRIES > 4) begin : g_bad_instruction_translation_buffer
            $error("INSTRUCTION_TRANSLATION_BUFFER_ENTRIES must be 1 to 4");
        end
    endgenerate

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic logic is_data_array1(input logic [31:0] a);
        is_data_array1 = (a[uma_pkg::DA1_SEL_HI:uma_pkg::DA1_SEL_LO] == uma_pkg::DA1_SEL);
    endfunction

    function automatic logic is_addr_array(input logic [31:0] a);
        is_addr_array = (a[uma_pkg::AA_SEL_HI:uma_pkg::AA_SEL_LO] == uma_pkg::AA_SEL);
    endfunction

    function automatic logic [31:0] pack_entry(input uma_pkg::uma_entry_s e);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[uma_pkg::PPN_HI:uma_pkg::PPN_LO] = e.physical_page_number;
        w[uma_pkg::VALID_BIT] = e.valid;
        w[uma_pkg::SZ_HI_BIT] = e.page_size_code[1];
        w[uma_pkg::PR_HI:uma_pkg::PR_LO] = e.protection_code;
        w[uma_pkg::SZ_LO_BIT] = e.page_size_code[0];
        w[uma_pkg::CACHE_BIT] = e.cacheable;
        w[uma_pkg::DIRTY_BIT] = e.dirty;
        w[uma_pkg::SHARED_BIT] = e.shared_page_flag;
        w[uma_pkg::WT_BIT] = e.write_through_flag;
        pack_entry = w;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    uma_pkg::uma_entry_s [UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] unified_translation_buffer_reg;
    uma_pkg::uma_entry_s [UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] unified_translation_buffer_next;
    uma_pkg::uma_entry_s [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] instruction_translation_buffer_reg;
    uma_pkg::uma_entry_s [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] instruction_translation_buffer_next;
    uma_pkg::uma_rsp_s rsp_reg;
    uma_pkg::uma_rsp_s rsp_next;

    // ------------------------------------------------------------
    // Associative comparison
    // ------------------------------------------------------------
    logic [uma_pkg::VPN_W-1:0] cmp_vpn;
    logic [UNIFIED_TRANSLATION_BUFFER_ENTRIES-1:0] u_hit;
    logic u_any;
    logic u_multi;
    logic [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] i_hit;
    logic i_any;
    logic i_multi;
    logic [5:0] u_idx;

    assign cmp_vpn = i_req.wdata[uma_pkg::VPN_HI:uma_pkg::VPN_LO];

    // Both buffers see the same key in the same cycle
    uma_match #(
        .ENTRIES(UNIFIED_TRANSLATION_BUFFER_ENTRIES)
    ) u_umatch (
        .i_entries(unified_translation_buffer_reg),
        .i_vpn(cmp_vpn),
        .i_asid(i_asid),
        .o_hit(u_hit),
        .o_any(u_any),
        .o_multi(u_multi)
    );

    uma_match #(
        .ENTRIES(INSTRUCTION_TRANSLATION_BUFFER_ENTRIES)
    ) u_imatch (
        .i_entries(instruction_translation_buffer_reg),
        .i_vpn(cmp_vpn),
        .i_asid(i_asid),
        .o_hit(i_hit),
        .o_any(i_any),
        .o_multi(i_multi)
    );

    // Index of the single unified hit; only meaningful without a multi-hit
    always_comb begin
        u_idx = 6'd0;
        for (int k = 0; k < UNIFIED_TRANSLATION_BUFFER_ENTRIES; k++) begin
            if (u_hit[k]) begin
                u_idx = 6'(k);
            end
        end
    end

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        uma_pkg::uma_entry_s upd;
        logic [5:0] sel;
        upd = '0;
        sel = i_req.addr[uma_pkg::IDX_HI:uma_pkg::IDX_LO];
        unified_translation_buffer_next = unified_translation_buffer_reg;
        instruction_translation_buffer_next = instruction_translation_buffer_reg;
        rsp_next = rsp_reg;
        if (i_ce) begin
            rsp_next.ack = 1'b0;
            rsp_next.multi_hit = 1'b0;
            // Refill path; a core access in the same cycle wins below
            if (i_fill.unified_translation_buffer_en) begin
                unified_translation_buffer_next[i_fill.unified_translation_buffer_index].virtual_page_number = i_fill.virtual_page_number;
                unified_translation_buffer_next[i_fill.unified_translation_buffer_index].address_space_identifier =
                    i_fill.address_space_identifier;
            end
            if (i_fill.instruction_translation_buffer_en) begin
                instruction_translation_buffer_next[i_fill.instruction_translation_buffer_index[1:0]] = unified_translation_buffer_reg[i_fill.unified_translation_buffer_index];
            end
            if (i_req.valid) begin
                rsp_next.ack = 1'b1;
                rsp_next.rdata = uma_pkg::RDATA_RESET;
                if (is_data_array1(i_req.addr)) begin
                    if (i_req.write) begin
                        upd = unified_translation_buffer_reg[sel];
                        upd.physical_page_number =
                            i_req.wdata[uma_pkg::PPN_HI:uma_pkg::PPN_LO];
                        upd.valid = i_req.wdata[uma_pkg::VALID_BIT];
                        upd.page_size_code = {i_req.wdata[uma_pkg::SZ_HI_BIT],
                                              i_req.wdata[uma_pkg::SZ_LO_BIT]};
                        upd.protection_code = i_req.wdata[uma_pkg::PR_HI:uma_pkg::PR_LO];
                        upd.cacheable = i_req.wdata[uma_pkg::CACHE_BIT];
                        upd.dirty = i_req.wdata[uma_pkg::DIRTY_BIT];
                        upd.shared_page_flag = i_req.wdata[uma_pkg::SHARED_BIT];
                        upd.write_through_flag = i_req.wdata[uma_pkg::WT_BIT];
                        unified_translation_buffer_next[sel] = upd;
                    end else begin
                        rsp_next.rdata = pack_entry(unified_translation_buffer_reg[sel]);
                    end
                end else if (is_addr_array(i_req.addr) && i_req.write
                             && i_req.addr[uma_pkg::AA_ASSOC_BIT]) begin
                    if (u_multi) begin
                        // Exception: no entry is touched in either buffer
                        rsp_next.multi_hit = 1'b1;
                    end else begin
                        upd = unified_translation_buffer_reg[u_idx];
                        upd.dirty = i_req.wdata[uma_pkg::AA_DIRTY_BIT];
                        upd.valid = i_req.wdata[uma_pkg::AA_VALID_BIT];
                        if (u_any) begin
                            unified_translation_buffer_next[u_idx] = upd;
                        end
                        for (int j = 0; j < INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; j++) begin
                            if (i_hit[j]) begin
                                if (u_any) begin
                                    instruction_translation_buffer_next[j] = upd;
                                end else begin
                                    instruction_translation_buffer_next[j].valid =
                                        i_req.wdata[uma_pkg::AA_VALID_BIT];
                                end
                            end
                        end
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            unified_translation_buffer_reg <= '0;
            instruction_translation_buffer_reg <= '0;
            rsp_reg <= '0;
        end else begin
            unified_translation_buffer_reg <= unified_translation_buffer_next;
            instruction_translation_buffer_reg <= instruction_translation_buffer_next;
            rsp_reg <= rsp_next;
        end
    end

    // Valid bits of the instruction buffer, for visibility of its updates
    logic [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] ivalid_reg;
    logic [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] ivalid_next;

    always_comb begin
        for (int j = 0; j < INSTRUCTION_TRANSLATION_BUFFER_ENTRIES; j++) begin
            ivalid_next[j] = instruction_translation_buffer_next[j].valid;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ivalid_reg <= '0;
        end else begin
            ivalid_reg <= ivalid_next;
        end
    end

    assign o_rsp = rsp_reg;
    assign o_instruction_translation_buffer_valid = ivalid_reg;

endmodule // uma_top

// ### design/uma_pkg.sv
/*
 * Shared constants and carrier types for the translation buffer
 * mapped-array access block.
 * Assumes a 32-bit core access port on the same clock as the block.
 */
package uma_pkg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    // Data array 1 window: top nine address bits equal 1_1110_1110
    localparam logic [8:0] DA1_SEL = 9'h1ee;
    localparam int DA1_SEL_HI = 31;
    localparam int DA1_SEL_LO = 23;
    // Address array window: top eight address bits
    localparam logic [7:0] AA_SEL = 8'hf6;
    localparam int AA_SEL_HI = 31;
    localparam int AA_SEL_LO = 24;
    localparam int AA_ASSOC_BIT = 7;
    localparam int IDX_HI = 13;
    localparam int IDX_LO = 8;

    // ------------------------------------------------------------
    // Data word layout
    // ------------------------------------------------------------
    localparam int PPN_HI = 28;
    localparam int PPN_LO = 10;
    localparam int VALID_BIT = 8;
    localparam int SZ_HI_BIT = 7;
    localparam int PR_HI = 6;
    localparam int PR_LO = 5;
    localparam int SZ_LO_BIT = 4;
    localparam int CACHE_BIT = 3;
    localparam int DIRTY_BIT = 2;
    localparam int SHARED_BIT = 1;
    localparam int WT_BIT = 0;
    // Address array data word
    localparam int VPN_HI = 31;
    localparam int VPN_LO = 10;
    localparam int AA_DIRTY_BIT = 9;
    localparam int AA_VALID_BIT = 8;

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int UNIFIED_TRANSLATION_BUFFER_ENTRIES = 64;
    localparam int INSTRUCTION_TRANSLATION_BUFFER_ENTRIES = 4;
    localparam int VPN_W = 22;
    localparam int ASID_W = 8;
    localparam int PPN_W = 19;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [VPN_W-1:0] virtual_page_number;
        logic [ASID_W-1:0] address_space_identifier;
        logic [PPN_W-1:0] physical_page_number;
        logic valid;
        logic [1:0] page_size_code;
        logic [1:0] protection_code;
        logic cacheable;
        logic dirty;
        logic shared_page_flag;
        logic write_through_flag;
    } uma_entry_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } uma_req_s;

    typedef struct packed {
        logic unified_translation_buffer_en;
        logic instruction_translation_buffer_en;
        logic [5:0] unified_translation_buffer_index;
        logic [1:0] instruction_translation_buffer_index;
        logic [VPN_W-1:0] virtual_page_number;
        logic [ASID_W-1:0] address_space_identifier;
    } uma_fill_s;

    typedef struct packed {
        logic ack;
        logic multi_hit;
        logic [31:0] rdata;
    } uma_rsp_s;

endpackage

// ### design/uma_match.sv
/*
 * Associative comparator: checks one virtual page number and address
 * space identifier against every entry of a translation buffer.
 * Purely combinational; the caller registers whatever it keeps.
 */
`timescale 1ns/1ps
module uma_match #(
    parameter int ENTRIES = 4
) (
    input wire uma_pkg::uma_entry_s [ENTRIES-1:0] i_entries,
    input wire logic [uma_pkg::VPN_W-1:0] i_vpn,
    input wire logic [uma_pkg::ASID_W-1:0] i_asid,
    output logic [ENTRIES-1:0] o_hit,
    output logic o_any,
    output logic o_multi
);

    // Page size code selects how many low page-number bits are ignored
    function automatic logic [uma_pkg::VPN_W-1:0] size_mask(input logic [1:0] sz);
        case (sz)
            2'b00: size_mask = 22'h3f_ffff;
            2'b01: size_mask = 22'h3f_fffc;
            2'b10: size_mask = 22'h3f_ffc0;
            default: size_mask = 22'h3f_fc00;
        endcase
    endfunction

    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_cmp
            logic [uma_pkg::VPN_W-1:0] m;
            assign m = size_mask(i_entries[g].page_size_code);
            // Shared pages match under any address space identifier
            assign o_hit[g] = i_entries[g].valid
                && ((i_entries[g].virtual_page_number & m) == (i_vpn & m))
                && (i_entries[g].shared_page_flag
                    || (i_entries[g].address_space_identifier == i_asid));
        end
    endgenerate

    always_comb begin
        o_any = |o_hit;
        // More than one bit set: clearing the lowest set bit leaves any
        o_multi = |(o_hit & (o_hit - ENTRIES'(1)));
    end

endmodule // uma_match

// ### sim/uma_properties.sv
/* Port checker for uma_top.
   Assumes one clock domain and i_ce held high. */
`timescale 1ns/1ps
module uma_properties #(
    parameter int INSTRUCTION_TRANSLATION_BUFFER_ENTRIES = 4
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire uma_pkg::uma_req_s i_req,
    input wire uma_pkg::uma_fill_s i_fill,
    input wire uma_pkg::uma_rsp_s o_rsp,
    input wire logic [INSTRUCTION_TRANSLATION_BUFFER_ENTRIES-1:0] o_instruction_translation_buffer_valid
);
    // --------
    // Checks
    // --------
    logic aw;
    logic rd1;
    assign aw = i_req.valid && i_req.write && i_req.addr[31:24] == uma_pkg::AA_SEL
        && i_req.addr[uma_pkg::AA_ASSOC_BIT];
    assign rd1 = i_req.valid && !i_req.write && i_req.addr[31:23] == uma_pkg::DA1_SEL;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_ack_after_req: assert property (i_ce && i_req.valid |=> o_rsp.ack)
        else $error("no ack after request");
    a_ack_has_cause: assert property (o_rsp.ack |-> $past(i_req.valid))
        else $error("ack without request");
    a_multi_with_ack: assert property (o_rsp.multi_hit |-> o_rsp.ack)
        else $error("multi hit without ack");
    a_multi_cause: assert property (o_rsp.multi_hit |-> $past(aw))
        else $error("multi hit not from associative write");
    a_da1_no_multi: assert property (rd1 |=> !o_rsp.multi_hit)
        else $error("multi hit on data array read");
    a_rdata_zero: assert property (i_req.valid && !rd1 |=> o_rsp.rdata == 32'h0000_0000)
        else $error("read data not zero");
    a_rdata_spare: assert property (o_rsp.ack |-> o_rsp.rdata[31:29] == 3'h0 && !o_rsp.rdata[9])
        else $error("unassigned read bits set");
    a_instruction_translation_buffer_hold: assert property (!aw && !i_fill.instruction_translation_buffer_en |=> $stable(o_instruction_translation_buffer_valid))
        else $error("instruction valid changed");
    a_instruction_translation_buffer_no_set: assert property (aw && !i_fill.instruction_translation_buffer_en |=>
        (o_instruction_translation_buffer_valid & ~$past(o_instruction_translation_buffer_valid)) == '0) else $error("instruction valid set");
    a_multi_no_wr: assert property (aw && !i_fill.instruction_translation_buffer_en ##1 o_rsp.multi_hit |->
        $stable(o_instruction_translation_buffer_valid)) else $error("write on multi hit");
    cover property (o_rsp.multi_hit);
    cover property (o_rsp.ack && o_rsp.rdata != 32'h0000_0000);
    cover property ($fell(o_instruction_translation_buffer_valid[0]));
endmodule // uma_properties
bind uma_top uma_properties #(.INSTRUCTION_TRANSLATION_BUFFER_ENTRIES(INSTRUCTION_TRANSLATION_BUFFER_ENTRIES)) i_props (.i_clk(i_clk),
    .i_rst(i_rst), .i_ce(i_ce), .i_req(i_req), .i_fill(i_fill), .o_rsp(o_rsp),
    .o_instruction_translation_buffer_valid(o_instruction_translation_buffer_valid));

// ### sim/uma_core_model.sv
/* Core model: turns bench commands into port requests.
   Assumes commands last one cycle and answers come one cycle later. */
`timescale 1ns/1ps
module uma_core_model (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire uma_pkg::uma_req_s i_cmd,
    input wire logic i_ack,
    output uma_pkg::uma_req_s o_req,
    output logic o_late
);
    // ------------
    // Request bus
    // ------------
    logic [64:0] pat_reg = 65'h0;
    logic pend_reg = 1'b0;
    // Idle bus shows the inverse of its last value, never stale data
    assign o_req = i_cmd.valid ? i_cmd : {1'b0, pat_reg};
    always @(posedge i_clk) begin
        pat_reg <= o_req.valid ? ~o_req[64:0] : ~pat_reg;
        pend_reg <= !i_rst && o_req.valid;
        if (i_rst) begin
            o_late <= 1'b0;
        end else if (pend_reg && !i_ack) begin
            o_late <= 1'b1;
        end
    end
endmodule // uma_core_model

// ### sim/tb.sv
/* Self-checking bench for uma_top.
   Assumes the core model drives requests and i_ce stays high. */
`timescale 1ns/1ps
module tb;
    // -------
    // Setup
    // -------
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    uma_pkg::uma_req_s cmd = '0;
    uma_pkg::uma_req_s req;
    uma_pkg::uma_fill_s fil = '0;
    uma_pkg::uma_rsp_s rsp;
    logic [7:0] asid = 8'h3c;
    logic [3:0] itv;
    logic late;
    logic mh;
    logic [31:0] rd;
    logic [31:0] v5;
    logic [31:0] r;
    logic [5:0] ix;
    logic [21:0] vp = 22'h2a_5a5a;
    int failures = 0;
    int compares = 0;
    int seed = 74478;
    uma_top i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1), .i_req(req), .i_fill(fil),
        .i_asid(asid), .o_rsp(rsp), .o_instruction_translation_buffer_valid(itv));
    uma_core_model i_core (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .i_ack(rsp.ack),
        .o_req(req), .o_late(late));
    initial begin
        forever #50 i_clk = ~i_clk;
    end
    task summarize();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task acc(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk) cmd <= '{1'b1, w, a, d};
        @(posedge i_clk) cmd.valid <= 1'b0;
        #1;
        while (rsp.ack !== 1'b1 && n < 4) begin
            @(posedge i_clk) #1;
            n++;
        end
        if (n == 4) begin
            failures++;
            summarize();
        end
        rd = rsp.rdata;
        mh = rsp.multi_hit;
    endtask
    task fill(input logic u, input logic it, input logic [5:0] ui);
        @(posedge i_clk) fil <= '{u, it, ui, 2'h0, vp, asid};
        @(posedge i_clk) fil <= '0;
    endtask
    // Filler bits outside the select and index fields are random on purpose
    function logic [31:0] da1(input logic [5:0] i);
        return {uma_pkg::DA1_SEL, 9'($random(seed)), i, 8'($random(seed))};
    endfunction
    function logic [31:0] expv(input logic [31:0] d);
        return d & 32'h1fff_fdff;
    endfunction
    task aw(input logic [1:0] dv);
        acc(1'b1, 32'hf600_0080, {vp, dv, 8'h00});
    endtask
    // ----------
    // Sequence
    // ----------
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        acc(1'b0, da1(6'h05), 32'h0);
        chk("reset entry", rd, 32'h0);
        v5 = ($random(seed) & 32'h1fff_fc69) | 32'h0000_0100;
        acc(1'b1, da1(6'h05), v5);
        fill(1'b1, 1'b0, 6'h05);
        fill(1'b0, 1'b1, 6'h05);
        aw(2'h3);
        chk("hit multi", 32'(mh), 32'h0);
        acc(1'b0, da1(6'h05), 32'h0);
        chk("dirty set", rd, expv(v5 | 32'h4));
        chk("instruction_translation_buffer kept", 32'(itv), 32'h1);
        vp = vp ^ 22'h1;
        aw(2'h0);
        vp = vp ^ 22'h1;
        chk("miss multi", 32'(mh), 32'h0);
        @(posedge i_clk) asid <= 8'h3d;
        aw(2'h0);
        @(posedge i_clk) asid <= 8'h3c;
        acc(1'b0, da1(6'h05), 32'h0);
        chk("miss entry", rd, expv(v5 | 32'h4));
        chk("miss instruction_translation_buffer", 32'(itv), 32'h1);
        aw(2'h2);
        acc(1'b0, da1(6'h05), 32'h0);
        chk("valid clear", rd, expv((v5 | 32'h4) & ~32'h100));
        chk("both instruction_translation_buffer", 32'(itv), 32'h0);
        acc(1'b1, da1(6'h05), v5);
        fill(1'b0, 1'b1, 6'h05);
        acc(1'b1, da1(6'h05), v5 & ~32'h100);
        aw(2'h0);
        chk("instruction_translation_buffer only", 32'(itv), 32'h0);
        acc(1'b1, da1(6'h05), v5);
        acc(1'b1, da1(6'h09), v5);
        fill(1'b1, 1'b0, 6'h09);
        aw(2'h3);
        chk("multi hit", 32'(mh), 32'h1);
        acc(1'b0, da1(6'h05), 32'h0);
        chk("multi no write", rd, expv(v5));
        // Largest page size: a key that differs in the low ten page bits still hits
        acc(1'b1, da1(6'h09), 32'h0);
        acc(1'b1, da1(6'h05), v5 | 32'h0000_0090);
        vp = vp ^ 22'h3ff;
        aw(2'h3);
        vp = vp ^ 22'h3ff;
        chk("size multi", 32'(mh), 32'h0);
        acc(1'b0, da1(6'h05), 32'h0);
        chk("size entry", rd, expv(v5 | 32'h0000_0094));
        chk("size instruction_translation_buffer", 32'(itv), 32'h0);
        for (int k = 0; k < 16; k++) begin
            ix = 6'($random(seed));
            r = $random(seed);
            acc(1'b1, da1(ix), r);
            acc(1'b1, {9'h1ef, r[22:0]}, ~r);
            acc(1'b0, da1(ix), 32'h0);
            chk("array word", rd, expv(r));
        end
        chk("core ack", 32'(late), 32'h0);
        summarize();
    end
endmodule // tb
